// *** design/sfc_flash_front.sv ***
// Function
// RQ1 - Frame starts at chip select fall: 8-bit opcode then address.
// RQ2 - Opcode, address and data travel most significant bit first.
// RQ3 - Modes 0 and 3: sample input on clock rise, shift output on fall.
// RQ4 - Host sends page read opcode, 24 address bits, 32 dummy bits.
// RQ5 - Page read address: reserved bit, 13-bit page, 10-bit byte offset.
// RQ6 - Page read never touches either buffer.
// RQ7 - After dummy bits each clock pulse shifts next data bit out.
// RQ8 - Page read wraps from last byte to first byte of same page.
// RQ9 - Chip select rise ends reading and releases the output pin.
// RQ10 - Host holds chip select low for the whole read frame.
// RQ11 - Buffer read opcodes select first or second buffer.
// RQ12 - Buffer read: 14 dummy, 10-bit offset, 8 dummy before data.
// RQ13 - Buffer read wraps from last byte to first buffer byte.
// RQ14 - Transfer opcodes pick buffer; reserved bit, page, 10 dummy bits.
// RQ15 - Transfer copying starts only at chip select rise.
// RQ16 - Status shows whether a transfer has finished.
// RQ17 - Compare opcodes pick buffer; reserved bit, page, 10 dummy bits.
// RQ18 - Compare of all page bytes runs after chip select rise, busy meanwhile.
// RQ19 - Compare outcome lands in status bit 6.
// RQ20 - Array of 8192 pages of 528 bytes plus two buffers.
// RQ21 - Other buffer accepts serial data while one is in use.
// RQ22 - Main array written only in whole pages; here mm_load writes the main array one byte at a time.
// RQ23 - Buffer write opcodes, 14 dummy bits, 10-bit start offset.
// RQ24 - Ready-busy pin low while transfer or compare runs.
// RQ25 - Unknown opcodes are ignored and start nothing.
// RQ26 - Host waits for ready before a new transfer or compare.
`timescale 1ns/1ns
`default_nettype none
module sfc_flash_front
    import sfc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    output logic so_out,
    output logic so_oe,
    output logic rdy_busy_n,
    output logic [7:0] status,
    input wire sfc_mwr_s mm_load
);
    // ----------------------------------------------------------------
    // Pin edges
    // ----------------------------------------------------------------
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic cs_fall;

    // RQ3 sampling edges
    sfc_edge #(.RST_VAL(1'b0)) u_sck_edge (
        .clk_sys(clk_sys),
        .srst(srst),
        .din(sck),
        .rise(sck_rise),
        .fall(sck_fall)
    );

    sfc_edge #(.RST_VAL(1'b1)) u_cs_edge (
        .clk_sys(clk_sys),
        .srst(srst),
        .din(cs_n),
        .rise(cs_rise),
        .fall(cs_fall)
    );

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0] bitcnt, next_bitcnt;
    logic [31:0] sr, next_sr;
    logic fetched, next_fetched;
    logic lk_ok, next_lk_ok;
    logic [OFF_AW-1:0] rd_off, next_rd_off;
    logic load_pend, next_load_pend;
    logic [7:0] nxt_byte, next_nxt_byte;
    logic [7:0] out_sr, next_out_sr;
    logic [2:0] bitpos, next_bitpos;
    logic next_so_out, next_so_oe;
    logic [6:0] wr_sr, next_wr_sr;
    logic [2:0] wr_cnt, next_wr_cnt;
    logic [OFF_AW-1:0] wr_off, next_wr_off;
    logic lk_rd_en, lk_wr_en;
    logic [OFF_AW-1:0] lk_rd_off;
    logic [7:0] lk_wr_data;

    sfc_eng_e eng_state, next_eng_state;
    logic [OFF_AW-1:0] idx, next_idx, idx_d, next_idx_d;
    logic vd, next_vd, mis, next_mis, eng_cmp, next_eng_cmp, eng_buf, next_eng_buf;
    logic [PAGE_AW-1:0] eng_page, next_eng_page;
    logic status_cmp, next_status_cmp, next_rdy_busy_n;
    logic [7:0] next_status;
    logic eng_rd_en, eng_wr_en, cmp_bad;

    sfc_cmd_e cmd;
    logic cbuf, hdr_done, is_read, cmd_ok, busy;
    logic [PAGE_AW-1:0] hdr_page;
    logic [OFF_AW-1:0] hdr_off;
    logic [7:0] rd_start, mm_q, rd_q;
    logic [BUF_COUNT-1:0][7:0] buf_q;
    logic mm_re;
    logic [MM_AW-1:0] mm_raddr;

    // ----------------------------------------------------------------
    // Header decode
    // ----------------------------------------------------------------
    // RQ1 opcode field
    assign cmd = sfc_decode(sr[31:HDR_OP_LSB]);
    // RQ11 buffer select
    assign cbuf = sfc_buf_sel(sr[31:HDR_OP_LSB]);
    // RQ5 page and offset fields
    assign hdr_page = sr[HDR_PAGE_MSB:HDR_PAGE_LSB];
    assign hdr_off = sr[OFF_AW-1:0];
    assign hdr_done = bitcnt >= HDR_BITS;
    assign is_read = (cmd == CMD_PAGE_RD) || (cmd == CMD_BUF_RD);
    // RQ4 and RQ12 dummy lengths
    assign rd_start = (cmd == CMD_PAGE_RD) ? PAGE_RD_START : BUF_RD_START;
    assign busy = eng_state != ENG_IDLE;
    // Main read port belongs to the engine while busy
    assign cmd_ok = (cmd == CMD_PAGE_RD) ? !busy : !(busy && eng_buf == cbuf);
    assign rd_q = (cmd == CMD_PAGE_RD) ? mm_q : buf_q[cbuf];

    // ----------------------------------------------------------------
    // Serial link
    // ----------------------------------------------------------------
    always_comb begin
        next_bitcnt = bitcnt;
        next_sr = sr;
        next_fetched = fetched;
        next_lk_ok = lk_ok;
        next_rd_off = rd_off;
        next_load_pend = load_pend;
        next_nxt_byte = nxt_byte;
        next_out_sr = out_sr;
        next_bitpos = bitpos;
        next_so_out = so_out;
        next_so_oe = so_oe;
        next_wr_sr = wr_sr;
        next_wr_cnt = wr_cnt;
        next_wr_off = wr_off;
        lk_rd_en = 1'b0;
        lk_rd_off = rd_off;
        lk_wr_en = 1'b0;
        lk_wr_data = {wr_sr, si};
        if (load_pend) begin
            next_nxt_byte = rd_q;
            next_load_pend = 1'b0;
        end
        if (cs_fall) begin
            // RQ1 new frame
            next_bitcnt = CNT_ZERO;
            next_sr = '0;
            next_fetched = 1'b0;
            next_lk_ok = 1'b0;
            next_bitpos = BIT_FIRST;
            next_wr_cnt = BIT_FIRST;
            next_so_oe = 1'b0;
        end else if (cs_n) begin
            // RQ9 release output
            next_so_oe = 1'b0;
        end else begin
            if (sck_rise) begin
                // RQ2 shift in
                if (!hdr_done) begin
                    next_sr = {sr[30:0], si};
                end
                if (bitcnt != CNT_MAX) begin
                    next_bitcnt = bitcnt + CNT_ONE;
                end
                // RQ23 buffer write bytes
                if (cmd == CMD_BUF_WR && hdr_done && lk_ok) begin
                    next_wr_sr = {wr_sr[5:0], si};
                    next_wr_cnt = wr_cnt + BIT_STEP;
                    if (wr_cnt == BIT_LAST) begin
                        lk_wr_en = 1'b1;
                        next_wr_off = sfc_off_inc(wr_off);
                    end
                end
            end
            if (hdr_done && !fetched) begin
                // RQ21 refuse the buffer in use; page reads are refused whenever busy
                next_fetched = 1'b1;
                next_lk_ok = cmd_ok;
                next_wr_off = hdr_off;
                if (is_read && cmd_ok) begin
                    lk_rd_en = 1'b1;
                    lk_rd_off = hdr_off;
                    next_rd_off = sfc_off_inc(hdr_off);
                    next_load_pend = 1'b1;
                end
            end
            // RQ7 data out on falling clock
            if (sck_fall && lk_ok && is_read && bitcnt >= rd_start) begin
                next_so_oe = 1'b1;
                next_bitpos = bitpos + BIT_STEP;
                if (bitpos == BIT_FIRST) begin
                    next_so_out = nxt_byte[7];
                    next_out_sr = {nxt_byte[6:0], 1'b0};
                    // RQ8 and RQ13 wrap within page or buffer
                    lk_rd_en = 1'b1;
                    next_rd_off = sfc_off_inc(rd_off);
                    next_load_pend = 1'b1;
                end else begin
                    next_so_out = out_sr[7];
                    next_out_sr = {out_sr[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bitcnt <= CNT_ZERO;
            sr <= '0;
            fetched <= 1'b0;
            lk_ok <= 1'b0;
            rd_off <= OFF_FIRST;
            load_pend <= 1'b0;
            nxt_byte <= 8'h00;
            out_sr <= 8'h00;
            bitpos <= BIT_FIRST;
            so_out <= 1'b0;
            so_oe <= 1'b0;
            wr_sr <= 7'h00;
            wr_cnt <= BIT_FIRST;
            wr_off <= OFF_FIRST;
        end else begin
            bitcnt <= next_bitcnt;
            sr <= next_sr;
            fetched <= next_fetched;
            lk_ok <= next_lk_ok;
            rd_off <= next_rd_off;
            load_pend <= next_load_pend;
            nxt_byte <= next_nxt_byte;
            out_sr <= next_out_sr;
            bitpos <= next_bitpos;
            so_out <= next_so_out;
            so_oe <= next_so_oe;
            wr_sr <= next_wr_sr;
            wr_cnt <= next_wr_cnt;
            wr_off <= next_wr_off;
        end
    end

    // ----------------------------------------------------------------
    // Transfer and compare engine
    // ----------------------------------------------------------------
    always_comb begin
        next_eng_state = eng_state;
        next_idx = idx;
        next_idx_d = idx_d;
        next_vd = vd;
        next_eng_cmp = eng_cmp;
        next_eng_buf = eng_buf;
        next_eng_page = eng_page;
        next_status_cmp = status_cmp;
        eng_rd_en = 1'b0;
        cmp_bad = vd && eng_cmp && (mm_q != buf_q[eng_buf]);
        next_mis = mis | cmp_bad;
        eng_wr_en = vd && !eng_cmp;
        case (eng_state)
            ENG_IDLE: begin
                // RQ14 RQ17 transfer or compare opcodes
                // RQ15 start on chip select rise; RQ25 unknown ops start nothing
                if (cs_rise && hdr_done && (cmd == CMD_XFR || cmd == CMD_CMP)) begin
                    next_eng_state = ENG_RUN;
                    next_idx = OFF_FIRST;
                    next_mis = 1'b0;
                    next_eng_cmp = cmd == CMD_CMP;
                    next_eng_buf = cbuf;
                    next_eng_page = hdr_page;
                end
            end
            ENG_RUN: begin
                // RQ18 walk every byte of the page
                eng_rd_en = 1'b1;
                next_vd = 1'b1;
                next_idx_d = idx;
                next_idx = sfc_off_inc(idx);
                if (idx == OFF_LAST) begin
                    next_eng_state = ENG_FLUSH;
                end
            end
            ENG_FLUSH: begin
                next_vd = 1'b0;
                next_eng_state = ENG_IDLE;
                // RQ19 outcome into status
                if (eng_cmp) begin
                    next_status_cmp = next_mis;
                end
            end
            default: begin
                next_eng_state = ENG_IDLE;
                next_vd = 1'b0;
            end
        endcase
        // RQ16 and RQ24 ready level follows engine
        next_rdy_busy_n = next_eng_state == ENG_IDLE;
        next_status = ST_RESET;
        next_status[ST_RDY_BIT] = next_rdy_busy_n;
        next_status[ST_CMP_BIT] = next_status_cmp;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            eng_state <= ENG_IDLE;
            idx <= OFF_FIRST;
            idx_d <= OFF_FIRST;
            vd <= 1'b0;
            mis <= 1'b0;
            eng_cmp <= 1'b0;
            eng_buf <= 1'b0;
            eng_page <= '0;
            status_cmp <= 1'b0;
            rdy_busy_n <= 1'b1;
            status <= ST_RESET;
        end else begin
            eng_state <= next_eng_state;
            idx <= next_idx;
            idx_d <= next_idx_d;
            vd <= next_vd;
            mis <= next_mis;
            eng_cmp <= next_eng_cmp;
            eng_buf <= next_eng_buf;
            eng_page <= next_eng_page;
            status_cmp <= next_status_cmp;
            rdy_busy_n <= next_rdy_busy_n;
            status <= next_status;
        end
    end

    // ----------------------------------------------------------------
    // Arrays
    // ----------------------------------------------------------------
    assign mm_re = busy ? eng_rd_en : (lk_rd_en && cmd == CMD_PAGE_RD);
    assign mm_raddr = busy ? sfc_mm_addr(eng_page, idx) : sfc_mm_addr(hdr_page, lk_rd_off);

    // RQ20 main array; RQ22 page writes come only through the load port
    sfc_ram #(.DEPTH(MM_DEPTH), .AW(MM_AW)) u_main (
        .clk_sys(clk_sys),
        .srst(srst),
        .we(mm_load.en),
        .waddr(mm_load.addr),
        .wdata(mm_load.data),
        .re(mm_re),
        .raddr(mm_raddr),
        .rdata(mm_q)
    );

    for (genvar b = 0; b < BUF_COUNT; b++) begin : g_buf
        logic own;
        assign own = busy && (eng_buf == 1'(b));
        // RQ6 page reads never reach a buffer port
        sfc_ram #(.DEPTH(PAGE_BYTES), .AW(OFF_AW)) u_buf (
            .clk_sys(clk_sys),
            .srst(srst),
            .we(own ? eng_wr_en : (lk_wr_en && cbuf == 1'(b))),
            .waddr(own ? idx_d : wr_off),
            .wdata(own ? mm_q : lk_wr_data),
            .re(own ? (eng_rd_en && eng_cmp) : (lk_rd_en && cmd == CMD_BUF_RD && cbuf == 1'(b))),
            .raddr(own ? idx : lk_rd_off),
            .rdata(buf_q[b])
        );
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [9:0] busy_len, next_busy_len;

    always_comb begin
        next_busy_len = busy ? busy_len + 10'h001 : 10'h000;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            busy_len <= 10'h000;
        end else begin
            busy_len <= next_busy_len;
        end
    end

    a_so_release: assert property (@(posedge clk_sys) disable iff (srst) // RQ9
        cs_rise |=> !so_oe) else $error("output still driven after chip select rise");
    a_xfr_start: assert property (@(posedge clk_sys) disable iff (srst) // RQ15
        $rose(busy) |-> $past(cs_rise) && $past(hdr_done)) else $error("engine started off frame end");
    a_cmp_start: assert property (@(posedge clk_sys) disable iff (srst) // RQ18
        (!busy && cs_rise && hdr_done && cmd == CMD_CMP) |=> busy && eng_cmp)
        else $error("compare did not start");
    a_busy_len: assert property (@(posedge clk_sys) disable iff (srst) // RQ18
        $fell(busy) |-> $past(busy_len) == BUSY_CYCLES - 10'h001) else $error("busy length wrong");
    a_rdy_mirror: assert property (@(posedge clk_sys) disable iff (srst) // RQ24
        rdy_busy_n == !busy && status[ST_RDY_BIT] == rdy_busy_n) else $error("ready pin mismatch");
    a_cmp_bit: assert property (@(posedge clk_sys) disable iff (srst) // RQ19
        $changed(status[ST_CMP_BIT]) |-> $past(eng_state) == ENG_FLUSH && $past(eng_cmp))
        else $error("compare bit changed outside compare end");
    a_unknown_op: assert property (@(posedge clk_sys) disable iff (srst) // RQ25
        (!busy && cs_rise && cmd == CMD_NONE) |=> !busy [*2]) else $error("unknown opcode started");
    a_page_nobuf: assert property (@(posedge clk_sys) disable iff (srst) // RQ6
        (!cs_n && cmd == CMD_PAGE_RD) |-> !lk_wr_en) else $error("page read wrote a buffer");
    a_rd_wrap: assert property (@(posedge clk_sys) disable iff (srst) // RQ8
        (lk_rd_en && lk_rd_off == OFF_LAST && !cs_n) |=> rd_off == OFF_FIRST)
        else $error("read offset did not wrap");
    a_oe_late: assert property (@(posedge clk_sys) disable iff (srst) // RQ7
        $rose(so_oe) |-> $past(bitcnt) >= $past(rd_start) && $past(sck_fall))
        else $error("output enabled before dummy bits ended");
endmodule : sfc_flash_front
`default_nettype wire

// *** design/sfc_pkg.sv ***
package sfc_pkg;

    // ----------------------------------------------------------------
    // Array geometry
    // ----------------------------------------------------------------
    localparam int PAGE_BYTES = 528;
    localparam int PAGE_COUNT = 8192;
    localparam int BUF_COUNT = 2;
    localparam int PAGE_AW = 13;
    localparam int OFF_AW = 10;
    localparam int MM_AW = 23;
    localparam int MM_DEPTH = PAGE_BYTES * PAGE_COUNT;
    localparam logic [OFF_AW-1:0] OFF_FIRST = 10'h000;
    localparam logic [OFF_AW-1:0] OFF_LAST = 10'h20F;

    // ----------------------------------------------------------------
    // Opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_PAGE_RD = 8'h52;
    localparam logic [7:0] OP_BUF1_RD = 8'h54;
    localparam logic [7:0] OP_BUF2_RD = 8'h56;
    localparam logic [7:0] OP_XFR1 = 8'h53;
    localparam logic [7:0] OP_XFR2 = 8'h55;
    localparam logic [7:0] OP_CMP1 = 8'h60;
    localparam logic [7:0] OP_CMP2 = 8'h61;
    localparam logic [7:0] OP_BUF1_WR = 8'h84;
    localparam logic [7:0] OP_BUF2_WR = 8'h87;

    // ----------------------------------------------------------------
    // Frame bit counts and header fields
    // ----------------------------------------------------------------
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] HDR_BITS = 8'h20;
    localparam logic [7:0] PAGE_RD_START = 8'h40;
    localparam logic [7:0] BUF_RD_START = 8'h28;
    localparam int HDR_OP_LSB = 24;
    localparam int HDR_PAGE_LSB = 10;
    localparam int HDR_PAGE_MSB = 22;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_STEP = 3'h1;

    // ----------------------------------------------------------------
    // Status byte
    // ----------------------------------------------------------------
    localparam int ST_RDY_BIT = 7;
    localparam int ST_CMP_BIT = 6;
    localparam logic [7:0] ST_RESET = 8'h80;
    localparam logic [9:0] BUSY_CYCLES = 10'h211;

    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_PAGE_RD = 3'h1,
        CMD_BUF_RD = 3'h2,
        CMD_BUF_WR = 3'h3,
        CMD_XFR = 3'h4,
        CMD_CMP = 3'h5
    } sfc_cmd_e;

    typedef enum logic [2:0] {
        ENG_IDLE = 3'b001,
        ENG_RUN = 3'b010,
        ENG_FLUSH = 3'b100
    } sfc_eng_e;

    typedef struct packed {
        logic en;
        logic [MM_AW-1:0] addr;
        logic [7:0] data;
    } sfc_mwr_s;

    function automatic sfc_cmd_e sfc_decode(input logic [7:0] op);
        case (op)
            OP_PAGE_RD: sfc_decode = CMD_PAGE_RD;
            OP_BUF1_RD, OP_BUF2_RD: sfc_decode = CMD_BUF_RD;
            OP_BUF1_WR, OP_BUF2_WR: sfc_decode = CMD_BUF_WR;
            OP_XFR1, OP_XFR2: sfc_decode = CMD_XFR;
            OP_CMP1, OP_CMP2: sfc_decode = CMD_CMP;
            default: sfc_decode = CMD_NONE;
        endcase
    endfunction : sfc_decode

    function automatic logic sfc_buf_sel(input logic [7:0] op);
        sfc_buf_sel = (op == OP_BUF2_RD) || (op == OP_XFR2) || (op == OP_CMP2)
            || (op == OP_BUF2_WR);
    endfunction : sfc_buf_sel

    function automatic logic [OFF_AW-1:0] sfc_off_inc(input logic [OFF_AW-1:0] off);
        sfc_off_inc = (off == OFF_LAST) ? OFF_FIRST : off + 10'h001;
    endfunction : sfc_off_inc

    function automatic logic [MM_AW-1:0] sfc_mm_addr(input logic [PAGE_AW-1:0] page,
                                                    input logic [OFF_AW-1:0] off);
        sfc_mm_addr = MM_AW'(page) * MM_AW'(PAGE_BYTES) + MM_AW'(off);
    endfunction : sfc_mm_addr

endpackage : sfc_pkg

// *** design/sfc_edge.sv ***
`timescale 1ns/1ns
`default_nettype none
module sfc_edge #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic din,
    output logic rise,
    output logic fall
);
    logic prev;
    logic next_prev;

    always_comb begin
        next_prev = din;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prev <= RST_VAL;
        end else begin
            prev <= next_prev;
        end
    end

    assign rise = din & ~prev;
    assign fall = ~din & prev;
endmodule : sfc_edge
`default_nettype wire

// *** design/sfc_ram.sv ***
`timescale 1ns/1ns
`default_nettype none
module sfc_ram #(
    parameter int DEPTH = 528,
    parameter int AW = 10
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic re,
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [DEPTH];
    logic [7:0] next_rdata;

    // Contents carry no reset, like the real array
    always_comb begin
        next_rdata = re ? mem[raddr] : rdata;
    end

    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        if (srst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule : sfc_ram
`default_nettype wire

// *** testbench/sfc_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module sfc_host (
    input wire logic clk_sys,
    input wire logic so_out,
    input wire logic so_oe,
    output logic cs_n,
    output logic sck,
    output logic si
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // Slow phases, device oversamples
    task automatic phase(input logic lvl);
        sck = lvl;
        repeat (3) @(posedge clk_sys) #1;
    endtask : phase
    task automatic frame(input logic [63:0] hdr, input int nb, input int nr,
                         output logic [31:0] rd);
        rd = '0;
        @(posedge clk_sys) #1;
        cs_n = 1'b0;
        for (int i = 0; i < nb; i++) begin
            si = hdr[63-i];
            phase(1'b0);
            phase(1'b1);
        end
        for (int i = 0; i < nr; i++) begin
            si = ~si;
            phase(1'b0);
            rd = {rd[30:0], so_oe ? so_out : 1'bx};
            phase(1'b1);
        end
        phase(1'b0);
        cs_n = 1'b1;
        // Idle line never keeps last bit
        si = ~si;
        // Frames need two idle edges between them
        repeat (2) @(posedge clk_sys) #1;
    endtask : frame
endmodule : sfc_host
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
    import sfc_pkg::*;
    logic clk_sys, srst, cs_n, sck, si, so_out, so_oe, rdy_busy_n;
    logic [7:0] status;
    sfc_mwr_s mwr;
    logic [31:0] rd;
    int mismatches, tests_run, cyc, n;
    sfc_flash_front u_dut (.clk_sys, .srst, .cs_n, .sck, .si, .so_out, .so_oe,
        .rdy_busy_n, .status, .mm_load(mwr));
    sfc_host u_host (.clk_sys, .so_out, .so_oe, .cs_n, .sck, .si);
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    // Hang guard, run needs about 5400 cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 10000) begin
            mismatches++;
            results();
        end
    end
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic poke(input int a, input logic [7:0] d);
        @(posedge clk_sys) #1;
        mwr = '{1'b1, MM_AW'(a), d};
        @(posedge clk_sys) #1;
        mwr.en = 1'b0;
    endtask : poke
    task automatic engine(input logic [7:0] op, input string what);
        u_host.frame({op, 1'b0, 13'h0005, 10'h000, 32'h0}, 32, 0, rd);
        repeat (3) @(posedge clk_sys) #1;
        check({what, " busy"}, {rdy_busy_n, status[7]}, 2'h0);
        n = 0;
        while (rdy_busy_n !== 1'b1 && n < 600) begin
            @(posedge clk_sys) #1;
            n++;
        end
        check({what, " time"}, n inside {[520:530]}, 1'b1);
    endtask : engine
    task automatic test_copy();
        // Whole page known, array has no reset
        for (int i = 0; i < PAGE_BYTES; i++) begin
            poke(5 * 528 + i, 8'(i));
        end
        poke(5 * 528 + 526, 8'hA5);
        poke(5 * 528 + 527, 8'h3C);
        poke(5 * 528, 8'h96);
        engine(8'h53, "transfer");
        engine(8'h60, "compare same");
        check("compare same", status[6], 1'b0);
        $display("test copy done");
    endtask : test_copy
    task automatic test_reads();
        poke(5 * 528, 8'h00);
        u_host.frame({8'h52, 1'b0, 13'h0005, 10'h20E, 32'h0}, 64, 24, rd);
        check("page read", rd[23:0], 24'hA53C00);
        repeat (3) @(posedge clk_sys) #1;
        check("output release", so_oe, 1'b0);
        u_host.frame({8'h54, 14'h0000, 10'h20F, 8'h00, 24'h0}, 40, 16, rd);
        check("buffer read", rd[15:0], 16'h3C96);
        $display("test reads done");
    endtask : test_reads
    task automatic test_mismatch();
        engine(8'h60, "compare diff");
        check("compare diff", status[6], 1'b1);
        u_host.frame({8'hFF, 1'b0, 13'h0005, 10'h000, 32'h0}, 32, 0, rd);
        repeat (3) @(posedge clk_sys) #1;
        check("unknown opcode", rdy_busy_n, 1'b1);
        $display("test mismatch done");
    endtask : test_mismatch
    task automatic test_write();
        u_host.frame({8'h53, 1'b0, 13'h0005, 10'h000, 32'h0}, 32, 0, rd);
        u_host.frame({8'h87, 14'h0000, 10'h20F, 8'h5A, 8'hC3, 16'h0}, 48, 0, rd);
        check("write while busy", rdy_busy_n, 1'b0);
        while (rdy_busy_n !== 1'b1) begin
            @(posedge clk_sys) #1;
        end
        // Clock parked high for a mode 3 frame
        u_host.phase(1'b1);
        u_host.frame({8'h56, 14'h0000, 10'h20F, 8'h00, 24'h0}, 40, 16, rd);
        check("buffer two", rd[15:0], 16'h5AC3);
        $display("test write done");
    endtask : test_write
    initial begin
        srst = 1'b1;
        mwr = '0;
        mismatches = 0;
        tests_run = 0;
        cyc = 0;
        repeat (3) @(posedge clk_sys) #1;
        srst = 1'b0;
        check("reset state", {so_oe, rdy_busy_n, status}, 10'h180);
        test_copy();
        test_reads();
        test_mismatch();
        test_write();
        results();
    end
endmodule : tb
`default_nettype wire
